// ===== verilog/cpac_pkg.sv
// shared constants and types for the code-protect gate and its checksum master
package cpac_pkg;
  localparam int unsigned WORD_W        = 12;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned SUM_W         = 16;
  localparam int unsigned ID_COUNT      = 4;
  localparam logic [11:0] CFG_ADDR      = 12'h0FFF;
  localparam logic [11:0] LOW_SEG_TOP   = 12'h003F;
  localparam logic [11:0] UP_SEG_BASE   = 12'h0040;
  localparam logic [11:0] ID_BASE_1K    = 12'h0400;
  localparam logic [11:0] ID_BASE_2K    = 12'h0800;
  localparam logic [11:0] TOP_1K        = 12'h03FF;
  localparam logic [11:0] TOP_2K        = 12'h07FF;
  localparam logic [11:0] TOP_SMALL     = 12'h017F;
  localparam int unsigned PROT_FIELD_LSB = 3;
  localparam logic [7:0]  PROT_ON_PAT   = 8'h00;
  localparam logic [11:0] CFG_RESET     = 12'h0FFF;
  localparam logic [11:0] MASK_OLD      = 12'h000F;
  localparam logic [11:0] MASK_NEW      = 12'h0FFF;
  localparam logic [11:0] MASK_SMALL    = 12'h000B;
  localparam logic [15:0] OLD_BIAS      = 16'h0FF0;
  localparam logic [3:0]  NIB_MASK      = 4'hF;

  // read behaviour of the device variant
  typedef enum logic [1:0] {
    CPAC_RD_SCRAMBLE,
    CPAC_RD_ZERO,
    CPAC_RD_ROM
  } cpac_variant_t;

  // checksum recipe chosen by the master
  typedef enum logic [2:0] {
    CPAC_CK_OLD,
    CPAC_CK_NEW,
    CPAC_CK_SMALL
  } cpac_recipe_t;
endpackage : cpac_pkg

// ===== verilog/cpac_if.sv
// link between the protected memory and the programmer
`timescale 1ns/1ps
interface cpac_if;
  logic        req;
  logic        we;
  logic [11:0] addr;
  logic [11:0] wdata;
  logic        ack;
  logic [11:0] rdata;
  logic        wr_blocked;
  modport device (input req, we, addr, wdata, output ack, rdata, wr_blocked);
  modport host   (output req, we, addr, wdata, input ack, rdata, wr_blocked);
endinterface : cpac_if

// ===== verilog/cpac_device.sv
// protected program memory with read gating and write blocking
`timescale 1ns/1ps
// Contract
// - protect on when field bits are all zero
// - unprotected: all reads plain, all writes to low, upper, config and id words accepted except in the rom variant
// - config word at 0xFFF, writable except in the rom variant
// - four id words above user space
// - scrambled variant: upper segment scrambled, write-blocked
// - scrambled variant: low, config, id scrambled, writable
// - zero variant: upper segment reads zero, write-blocked
// - zero variant: low, config, id plain, writable
// - scramble low nibble is xor of three nibbles
// - programmer sums memory modulo 16 bits
// - programmer adds masked config and id value
// - programmer may sum device readout directly
// - programmer models protected readout from source data
// - older unprotected: mask 0x00F, add 0x0FF0
// - older protected: nibble fold sum plus config
// - newer unprotected: full sum plus config 0xFFF
// - newer protected: low sum, config, packed id
// - packed id: four nibbles, first most significant
// - smallest part masks config with 0x00B
module cpac_device #(
  parameter cpac_pkg::cpac_variant_t VARIANT = cpac_pkg::CPAC_RD_SCRAMBLE,
  parameter int unsigned             DEPTH   = 2048
) (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  cpac_if.device      link,
  output logic        protect_enable_o,
  output logic [11:0] config_word_value_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [11:0] USER_TOP = 12'(DEPTH - 1);
  localparam logic [11:0] ID_BASE  = 12'(DEPTH);

  // refuse memory sizes the segment decode cannot serve
  if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048 && DEPTH != 384) begin : g_bad_depth
    $error("cpac_device: unsupported DEPTH");
  end

  logic [11:0] mem [DEPTH];
  logic [11:0] id_q [cpac_pkg::ID_COUNT];
  logic [11:0] cfg_q;
  logic        ack_q;
  logic [11:0] rdata_q;
  logic        blk_q;

  // segment decode
  wire is_cfg  = (link.addr == cpac_pkg::CFG_ADDR);
  wire is_id   = (link.addr >= ID_BASE) && (link.addr < ID_BASE + 12'd4);
  wire is_low  = (link.addr <= cpac_pkg::LOW_SEG_TOP);
  wire is_up   = (link.addr >= cpac_pkg::UP_SEG_BASE) && (link.addr <= USER_TOP);
  wire [1:0] id_idx = link.addr[1:0];

  wire prot = (cfg_q[11:cpac_pkg::PROT_FIELD_LSB] == cpac_pkg::PROT_ON_PAT);
  wire rom  = (VARIANT == cpac_pkg::CPAC_RD_ROM);

  wire [11:0] raw = is_cfg ? cfg_q :
                    is_id  ? id_q[id_idx] :
                    (is_low || is_up) ? mem[link.addr[AW-1:0]] : 12'h0000;
  // scrambled view keeps upper nibbles, folds all three into the low nibble
  wire [11:0] scr = {raw[11:4], raw[11:8] ^ raw[7:4] ^ raw[3:0]};

  wire up_zero  = prot && is_up && (VARIANT != cpac_pkg::CPAC_RD_SCRAMBLE);
  wire use_scr  = prot && (VARIANT == cpac_pkg::CPAC_RD_SCRAMBLE);
  wire [11:0] rd_val = up_zero ? 12'h0000 : use_scr ? scr : raw;

  wire wr_ok  = !rom && (is_cfg || is_id || is_low || (is_up && !prot));
  wire do_wr  = link.req && link.we && wr_ok;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 12'h0000;
      blk_q   <= 1'b0;
      cfg_q   <= cpac_pkg::CFG_RESET;
    end else begin
      ack_q   <= link.req;
      rdata_q <= (link.req && !link.we) ? rd_val : rdata_q;
      blk_q   <= link.req && link.we && !wr_ok;
      if (do_wr && is_cfg)
        cfg_q <= link.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_wr && (is_low || is_up))
      mem[link.addr[AW-1:0]] <= link.wdata;
    if (do_wr && is_id)
      id_q[id_idx] <= link.wdata;
  end

  assign link.ack            = ack_q;
  assign link.rdata          = rdata_q;
  assign link.wr_blocked     = blk_q;
  assign protect_enable_o    = prot;
  assign config_word_value_o = cfg_q;
endmodule : cpac_device

// ===== verilog/cpac_host.sv
// programmer end: reads the memory and forms the 16-bit checksum
`timescale 1ns/1ps
module cpac_host #(
  parameter cpac_pkg::cpac_recipe_t RECIPE = cpac_pkg::CPAC_CK_NEW,
  parameter int unsigned            DEPTH  = 2048
) (
  input  wire logic   clk_i,
  input  wire logic   rstn_i,
  cpac_if.host        link,
  input  wire logic   start_i,
  input  wire logic   protect_enable_i,
  input  wire logic   model_protect_i,
  input  wire logic   wr_req_i,
  input  wire logic [11:0] wr_addr_i,
  input  wire logic [11:0] wr_data_i,
  output logic        wr_done_o,
  output logic        busy_o,
  output logic        done_o,
  output logic [15:0] checksum_o
);
  localparam logic [11:0] TOP = 12'(DEPTH - 1);
  typedef enum logic [2:0] {CPAC_IDLE, CPAC_WR, CPAC_MEM, CPAC_CFG, CPAC_ID, CPAC_FIN} cpac_st_t;

  // refuse memory sizes the address walk cannot serve
  if (DEPTH != 512 && DEPTH != 1024 && DEPTH != 2048 && DEPTH != 384) begin : g_bad_depth
    $error("cpac_host: unsupported DEPTH");
  end

  cpac_st_t    st_q, st_d;
  logic [11:0] addr_q, addr_d;
  logic        pend_q, pend_d;
  logic [15:0] sum_q, sum_d;
  logic [15:0] pid_q, pid_d;
  logic [1:0]  idn_q, idn_d;

  wire        prot      = protect_enable_i || model_protect_i;
  wire [11:0] w         = link.rdata;
  wire [15:0] fold      = {12'h000, w[11:8] ^ w[7:4] ^ w[3:0]};
  wire        xor_prot  = (RECIPE != cpac_pkg::CPAC_CK_NEW) && prot;
  wire        new_prot  = (RECIPE == cpac_pkg::CPAC_CK_NEW) && prot;
  // a scrambled readout already carries the fold in its low nibble; source data is folded here
  wire [15:0] rd_fold   = {12'h000, w[3:0]};
  wire [15:0] xor_term  = protect_enable_i ? rd_fold : fold;
  wire [15:0] mem_term  = xor_prot ? xor_term : {4'h0, w};
  wire [11:0] mem_top   = new_prot ? cpac_pkg::LOW_SEG_TOP : TOP;
  wire [11:0] cfg_mask  = (RECIPE == cpac_pkg::CPAC_CK_SMALL) ? cpac_pkg::MASK_SMALL :
                          (RECIPE == cpac_pkg::CPAC_CK_OLD)   ? cpac_pkg::MASK_OLD :
                                                                cpac_pkg::MASK_NEW;
  wire [15:0] cfg_term  = {4'h0, w & cfg_mask};
  wire [15:0] bias      = ((RECIPE == cpac_pkg::CPAC_CK_OLD) && !prot) ?
                          cpac_pkg::OLD_BIAS : 16'h0000;
  wire [11:0] id_base   = 12'(DEPTH);
  wire        rd_back   = pend_q && link.ack;

  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    pend_d = pend_q;
    sum_d  = sum_q;
    pid_d  = pid_q;
    idn_d  = idn_q;
    case (st_q)
      CPAC_IDLE: begin
        if (wr_req_i) begin
          st_d = CPAC_WR;
        end else if (start_i) begin
          st_d = CPAC_MEM; addr_d = 12'h000; sum_d = 16'h0000; pid_d = 16'h0000;
          pend_d = 1'b0;
        end
      end
      CPAC_WR: st_d = CPAC_IDLE;
      CPAC_MEM: begin
        pend_d = !pend_q;
        if (rd_back) begin
          sum_d = sum_q + mem_term;
          if (addr_q == mem_top) begin
            st_d = CPAC_CFG; addr_d = cpac_pkg::CFG_ADDR;
          end else begin
            addr_d = addr_q + 12'd1;
          end
        end
      end
      CPAC_CFG: begin
        pend_d = !pend_q;
        if (rd_back) begin
          sum_d = sum_q + cfg_term + bias;
          if (new_prot) begin
            st_d = CPAC_ID; addr_d = id_base; idn_d = 2'd0;
          end else begin
            st_d = CPAC_FIN;
          end
        end
      end
      CPAC_ID: begin
        pend_d = !pend_q;
        if (rd_back) begin
          pid_d = {pid_q[11:0], w[3:0] & cpac_pkg::NIB_MASK};
          idn_d = idn_q + 2'd1;
          addr_d = addr_q + 12'd1;
          if (idn_q == 2'd3) st_d = CPAC_FIN;
        end
      end
      CPAC_FIN: begin
        sum_d = sum_q + pid_q;
        st_d  = CPAC_IDLE;
      end
      default: st_d = CPAC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= CPAC_IDLE; addr_q <= 12'h000; pend_q <= 1'b0;
      sum_q <= 16'h0000; pid_q <= 16'h0000; idn_q <= 2'd0;
    end else begin
      st_q <= st_d; addr_q <= addr_d; pend_q <= pend_d;
      sum_q <= sum_d; pid_q <= pid_d; idn_q <= idn_d;
    end
  end

  logic        done_q;
  logic [15:0] ck_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_q <= 1'b0;
      ck_q   <= 16'h0000;
    end else begin
      done_q <= (st_q == CPAC_FIN);
      ck_q   <= (st_q == CPAC_FIN) ? sum_d : ck_q;
    end
  end

  wire reading = (st_q == CPAC_MEM) || (st_q == CPAC_CFG) || (st_q == CPAC_ID);
  assign link.req   = (st_q == CPAC_WR) || (reading && !pend_q);
  assign link.we    = (st_q == CPAC_WR);
  assign link.addr  = (st_q == CPAC_WR) ? wr_addr_i : addr_q;
  assign link.wdata = wr_data_i;
  assign wr_done_o  = (st_q == CPAC_WR);
  assign busy_o     = (st_q != CPAC_IDLE);
  assign done_o     = done_q;
  assign checksum_o = ck_q;
endmodule : cpac_host

// ===== tb/cpac_monitor.sv
// link assertions for the code-protect gate
`timescale 1ns/1ps
module cpac_monitor #(
  parameter int unsigned DEPTH = 2048
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [11:0] addr,
  input  wire logic [11:0] wdata,
  input  wire logic        ack,
  input  wire logic [11:0] rdata,
  input  wire logic        wr_blocked
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic prot_q;
  wire  wr_w = req && we;
  wire  up_w = addr >= cpac_pkg::UP_SEG_BASE && addr < DEPTH;
  wire  id_w = addr >= DEPTH && addr < DEPTH + 4;
  // protect state follows every config write
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) prot_q <= 1'b0;
    else if (wr_w && addr == cpac_pkg::CFG_ADDR) prot_q <= wdata[11:3] == 9'h000;
  end
  chk_ack_after_req: assert property (req |=> ack)
    else $error("no ack one cycle after request");
  chk_idle_no_ack: assert property (!req |=> !ack)
    else $error("ack without request");
  chk_block_cause: assert property (wr_blocked |-> ack && $past(wr_w && prot_q && up_w))
    else $error("write refused without cause");
  chk_upper_block: assert property (wr_w && prot_q && up_w |=> wr_blocked)
    else $error("protected upper write not refused");
  chk_cfg_write: assert property (wr_w && addr == cpac_pkg::CFG_ADDR |=> !wr_blocked)
    else $error("config write refused");
  chk_low_write: assert property (wr_w && addr <= cpac_pkg::LOW_SEG_TOP |=> !wr_blocked)
    else $error("low segment write refused");
  chk_id_write: assert property (wr_w && id_w |=> !wr_blocked)
    else $error("id word write refused");
  chk_open_write: assert property (wr_w && !prot_q |=> !wr_blocked)
    else $error("unprotected write refused");
  chk_rdata_hold: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  cover property (wr_w && prot_q && up_w);
  cover property (req && !we && prot_q);
  cover property (wr_w && addr == cpac_pkg::CFG_ADDR);
endmodule : cpac_monitor

// ===== tb/code_protect_access_checksum_tb.sv
// bench: both link ends against a reference memory and checksum model
`timescale 1ns/1ps
module code_protect_access_checksum_tb;
  localparam int unsigned DEPTH = 384;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        start_i = 1'b0;
  logic        wr_req_i = 1'b0;
  logic [11:0] wr_addr_i = 12'h0000;
  logic [11:0] wr_data_i = 12'h0000;
  logic        prot_o, wr_done_o, busy_o, done_o, rd_pend = 1'b0;
  logic [11:0] cfg_o, exp_rd;
  logic [15:0] checksum_o;
  logic [11:0] mem [0:4095];
  logic [11:0] cfg = 12'h0FFF;
  logic [31:0] seed = 32'hcd23_f37d;
  logic [11:0] pa [4] = '{12'h003F, 12'h0040, 12'h017F, 12'h0180};
  int          mismatches = 0;
  int          tests_run = 0;
  cpac_if link ();
  always #2.5 clk_i = ~clk_i;
  cpac_device #(.VARIANT(cpac_pkg::CPAC_RD_SCRAMBLE), .DEPTH(DEPTH)) u_cpac_device (
    .clk_i(clk_i), .rstn_i(rstn_i), .link(link), .protect_enable_o(prot_o),
    .config_word_value_o(cfg_o));
  cpac_host #(.RECIPE(cpac_pkg::CPAC_CK_SMALL), .DEPTH(DEPTH)) u_cpac_host (
    .clk_i(clk_i), .rstn_i(rstn_i), .link(link), .start_i(start_i),
    .protect_enable_i(prot_o), .model_protect_i(1'b0), .wr_req_i(wr_req_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_done_o(wr_done_o),
    .busy_o(busy_o), .done_o(done_o), .checksum_o(checksum_o));
  cpac_monitor #(.DEPTH(DEPTH)) u_cpac_monitor (
    .clk_i(clk_i), .rstn_i(rstn_i), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .wr_blocked(link.wr_blocked));
  function automatic logic [11:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[11:0];
  endfunction : rnd
  function automatic logic prot();
    return cfg[11:3] == 9'h000;
  endfunction : prot
  function automatic logic [11:0] rdexp(input logic [11:0] a);
    logic [11:0] w;
    w = (a == cpac_pkg::CFG_ADDR) ? cfg : (a < DEPTH + 4) ? mem[a] : 12'h0000;
    if (prot() && w != 12'h0000) w[3:0] = w[11:8] ^ w[7:4] ^ w[3:0];
    return w;
  endfunction : rdexp
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic wr(input logic [11:0] a, input logic [11:0] d);
    int   n;
    logic blk;
    blk = prot() && a >= cpac_pkg::UP_SEG_BASE && a < DEPTH;
    @(negedge clk_i);
    wr_addr_i = a;
    wr_data_i = d;
    wr_req_i = 1'b1;
    for (n = 0; n < 20; n++) begin
      #1;
      if (wr_done_o === 1'b1) break;
      @(negedge clk_i);
    end
    if (n == 20) begin
      mismatches++;
      summarize();
    end
    @(negedge clk_i);
    wr_req_i = 1'b0;
    check("wr_blocked", {15'h0000, link.wr_blocked}, {15'h0000, blk});
    if (!blk) mem[a] = d;
    if (a == cpac_pkg::CFG_ADDR) begin
      cfg = d;
      check("config", {4'h0, cfg_o}, {4'h0, cfg});
      check("protect", {15'h0000, prot_o}, {15'h0000, prot()});
    end
  endtask : wr
  task automatic ck(input logic cmp);
    int          n;
    logic [15:0] s;
    s = {4'h0, cfg & cpac_pkg::MASK_SMALL};
    for (n = 0; n <= 16'h017F; n++) begin
      if (prot()) s = s + {12'h000, mem[n][11:8] ^ mem[n][7:4] ^ mem[n][3:0]};
      else s = s + {4'h0, mem[n]};
    end
    @(negedge clk_i);
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    for (n = 0; n < 5000 && done_o !== 1'b1; n++) @(negedge clk_i);
    if (n == 5000) begin
      mismatches++;
      summarize();
    end
    repeat (2) @(negedge clk_i);
    if (cmp) check("checksum", checksum_o, s);
    check("busy", {15'h0000, busy_o}, 16'h0000);
  endtask : ck
  // every read on the link is compared with the model
  always @(posedge clk_i) begin
    rd_pend <= link.req === 1'b1 && link.we === 1'b0;
    exp_rd <= rdexp(link.addr);
  end
  always @(negedge clk_i) begin
    if (rd_pend) check("rdata", {3'h0, link.ack, link.rdata}, {4'h1, exp_rd});
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    check("protect", {15'h0000, prot_o}, 16'h0000);
    for (int a = 0; a < DEPTH + 4; a++) wr(a[11:0], rnd());
    wr(cpac_pkg::CFG_ADDR, rnd() | 12'h0008);
    ck(1'b1);
    wr(cpac_pkg::CFG_ADDR, 12'h0005);
    foreach (pa[i]) wr(pa[i], rnd());
    ck(1'b1);
    wr(cpac_pkg::CFG_ADDR, 12'h0008);
    wr(12'h0040, rnd());
    ck(1'b1);
    summarize();
  end
endmodule : code_protect_access_checksum_tb
